// ==== bench/host_bus_model.sv ====
// Host processor model that drives the parallel port pins of the device.
// Assumes the bench resolves the data wire and calls xfer from one thread.
`timescale 1ns/1ns
`default_nettype none

module host_bus_model
    import host_port_pkg::*;
(
    input  wire logic  sys_clk,
    input  wire logic  dir_style,
    input  wire word_t bus,
    input  wire logic  bus_oe,
    output var  addr_t addr,
    output var  logic  rnw_wr_n,
    output wire logic  oe_rd_n,
    output var  logic  cs_n,
    output var  logic  drv,
    output var  word_t drv_val
);
    logic rd_q = 1'b1;

    assign oe_rd_n = dir_style ? 1'b0 : rd_q;

    initial
    begin
        addr = 12'h000;
        rnw_wr_n = 1'b1;
        cs_n = 1'b1;
        drv = 1'b0;
        drv_val = 16'h0000;
    end

    // Address and data settle three cycles before the strobe and stay put.
    task automatic xfer(input logic wr, input logic sel, input addr_t a,
                        input word_t d, output word_t q, output logic ok);
        int n;
        @(posedge sys_clk);
        #1;
        addr = a;
        drv = wr;
        drv_val = d;
        repeat (3) @(posedge sys_clk);
        #1;
        cs_n = !sel;
        rnw_wr_n = !wr;
        rd_q = wr;
        ok = 1'b0;
        for (n = 0; n < 8 && !ok; n++)
        begin
            @(posedge sys_clk);
            #1;
            ok = !wr && bus_oe === 1'b1;
        end
        repeat (2) @(posedge sys_clk);
        #1;
        q = bus;
        cs_n = 1'b1;
        rnw_wr_n = 1'b1;
        rd_q = 1'b1;
        drv = 1'b0;
        repeat (4) @(posedge sys_clk);
        #1;
    endtask
endmodule // host_bus_model

`default_nettype wire

// ==== bench/host_processor_port_tb.sv ====
// Self-checking bench for the host port: memory, select, interrupt, styles.
// Assumes host_bus_model beside it; the data wire floats to ~last value.
`timescale 1ns/1ns
`default_nettype none

module host_processor_port_tb
    import host_port_pkg::*;
;
    logic       sys_clk = 1'b0;
    logic       nrst = 1'b0;
    logic       style = 1'b1;
    logic [7:0] irq_event = 8'h00;
    word_t      dout, hwire, hval;
    word_t      last_q = 16'h0000;
    addr_t      addr;
    logic       doe, irq_out, irq_oe, drv, rnw, rd_n, cs_n;
    int         err_count = 0;
    int         n_compared = 0;
    int         cyc = 0;
    wire logic  irq_pin = irq_oe ? irq_out : 1'b1;

    always #4 sys_clk = ~sys_clk;
    always @(posedge sys_clk) last_q <= hwire;
    assign hwire = doe ? dout : (drv ? hval : ~last_q);

    host_processor_port i_dut (.sys_clk, .nrst, .style_dir_sel(style),
        .host_data_in(hwire), .host_data_out_q(dout), .host_data_oe_q(doe),
        .host_addr(addr), .host_rnw_wr_n(rnw), .host_oe_rd_n(rd_n),
        .host_cs_n(cs_n), .irq_event, .host_irq_n_out_q(irq_out),
        .host_irq_n_oe_q(irq_oe));

    host_bus_model i_host (.sys_clk, .dir_style(style), .bus(hwire),
        .bus_oe(doe), .addr, .rnw_wr_n(rnw), .oe_rd_n(rd_n), .cs_n, .drv,
        .drv_val(hval));

    task automatic check(input word_t seen, input word_t exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task close_out;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic do_reset(input logic dir);
        @(posedge sys_clk);
        #1;
        nrst = 1'b0;
        style = dir;
        repeat (3) @(posedge sys_clk);
        #1;
        check(doe, 1'b0);
        check(irq_pin, 1'b1);
        nrst = 1'b1;
        repeat (2) @(posedge sys_clk);
    endtask

    task automatic rd(input addr_t a, input logic sel, output word_t q,
                      output logic ok);
        i_host.xfer(1'b0, sel, a, 16'h0000, q, ok);
    endtask

    task automatic wr(input addr_t a, input word_t d, input logic sel);
        word_t q;
        logic  ok;
        i_host.xfer(1'b1, sel, a, d, q, ok);
    endtask

    task automatic t_mem;
        word_t q;
        logic  ok;
        word_t pat [3] = '{16'h8001, 16'h7ffe, 16'h5aa5};
        addr_t at [3] = '{12'h000, 12'hfef, 12'h555};
        foreach (at[i]) wr(at[i], pat[i], 1'b1);
        foreach (at[i])
        begin
            rd(at[i], 1'b1, q, ok);
            check(ok, 1'b1);
            check(q, pat[i]);
            check(doe, 1'b0);
        end
        $display("test mem done");
    endtask

    task automatic t_cs;
        word_t q;
        logic  ok;
        wr(12'h555, 16'h0ff0, 1'b0);
        rd(12'h555, 1'b0, q, ok);
        check(ok, 1'b0);
        rd(12'h555, 1'b1, q, ok);
        check(q, 16'h5aa5);
        $display("test cs done");
    endtask

    task automatic t_irq;
        word_t q;
        logic  ok;
        irq_event = 8'h08;
        @(posedge sys_clk);
        #1;
        irq_event = 8'h00;
        repeat (3) @(posedge sys_clk);
        #1;
        check(irq_pin, 1'b1);
        rd(12'hff0, 1'b1, q, ok);
        check(q, 16'h0008);
        wr(12'hff1, 16'h0008, 1'b1);
        check(irq_pin, 1'b0);
        rd(12'hff2, 1'b1, q, ok);
        check(q, 16'h0003);
        wr(12'hff0, 16'h0008, 1'b1);
        check(irq_pin, 1'b1);
        $display("test irq done");
    endtask

    task automatic t_strobe;
        word_t q;
        logic  ok;
        do_reset(1'b0);
        rd(12'hff1, 1'b1, q, ok);
        check(q, 16'h0000);
        wr(12'h123, 16'hc33c, 1'b1);
        rd(12'h123, 1'b1, q, ok);
        check(ok, 1'b1);
        check(q, 16'hc33c);
        rd(12'hff2, 1'b1, q, ok);
        check(q, 16'h0000);
        $display("test strobe done");
    endtask

    initial
    begin
        do_reset(1'b1);
        t_mem;
        t_cs;
        t_irq;
        t_strobe;
        close_out;
    end

    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            err_count++;
            close_out;
        end
    end
endmodule // host_processor_port_tb

`default_nettype wire

// ==== hw/host_port_params.svh ====
// Constants for the parallel host port: widths, map and timing.
// Assumes inclusion by host_port_pkg and the design modules only.
`ifndef HOST_PORT_PARAMS_SVH
`define HOST_PORT_PARAMS_SVH

`define HP_DATA_W       16
`define HP_ADDR_W       12
`define HP_IRQ_W        8
`define HP_MEM_DEPTH    4096
`define HP_MEM_AW       12
`define HP_CLK_MHZ      125
`define HP_NOM_CLK_MHZ  50
`define HP_IRQ_BASE     12'hff0
`define HP_IRQ_MSK_OFS  12'hff1
`define HP_STAT_OFS     12'hff2
`define HP_ZERO16       16'h0000
`define HP_ZERO8        8'h00
`define HP_CTL_IDLE     3'h7

`endif

// ==== hw/host_port_pkg.sv ====
// Types shared by the host port design files.
// Assumes the params header sits beside this file.
`include "host_port_params.svh"

package host_port_pkg;
    typedef enum logic [1:0]
    {
        STYLE_DIR    = 2'h1,
        STYLE_STROBE = 2'h2
    } bus_style_e;

    typedef enum logic [3:0]
    {
        ST_IDLE  = 4'h1,
        ST_WRITE = 4'h2,
        ST_READ  = 4'h4,
        ST_HOLD  = 4'h8
    } hp_state_e;

    typedef logic [`HP_DATA_W-1:0] word_t;
    typedef logic [`HP_ADDR_W-1:0] addr_t;
endpackage

// ==== hw/host_processor_port.sv ====
// Parallel host processor slave port with open-drain interrupt output.
// Assumes all pins asynchronous to sys_clk; strap style_dir_sel is stable.
// What this block does
// - Sixteen-bit two-way data between host and device.
// - Twelve-bit address selects register or memory word.
// - Direction style: low writes, high reads.
// - Strobe style: low write strobe stores data.
// - Strobe style: low read strobe returns data.
// - Chip select high: ignore bus, no access.
// - Chip select low: respond to bus inputs.
// - Interrupt pulled low while any pending condition has its mask bit set.
// - Active-low reset, clocked, restores initial state except the memory contents.
// - Everything runs on one system clock.
`timescale 1ns/1ns
`default_nettype none
`include "host_port_params.svh"

module host_processor_port
    import host_port_pkg::*;
#(
    parameter int DATA_W = `HP_DATA_W,
    parameter int ADDR_W = `HP_ADDR_W,
    parameter int IRQ_W  = `HP_IRQ_W
) (
    input  wire logic              sys_clk,
    input  wire logic              nrst,
    input  wire logic              style_dir_sel,
    input  wire logic [DATA_W-1:0] host_data_in,
    output var  logic [DATA_W-1:0] host_data_out_q,
    output var  logic              host_data_oe_q,
    input  wire logic [ADDR_W-1:0] host_addr,
    input  wire logic              host_rnw_wr_n,
    input  wire logic              host_oe_rd_n,
    input  wire logic              host_cs_n,
    input  wire logic [IRQ_W-1:0]  irq_event,
    output var  logic              host_irq_n_out_q,
    output var  logic              host_irq_n_oe_q
);
    // Synchronisers: the first stage is read only by the second.
    logic [DATA_W-1:0] din_s1_q, din_s2_q;
    logic [ADDR_W-1:0] adr_s1_q, adr_s2_q;
    logic [2:0]        ctl_s1_q, ctl_s2_q;
    logic              style_s1_q, style_s2_q;

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            din_s1_q <= '0;
            din_s2_q <= '0;
            adr_s1_q <= '0;
            adr_s2_q <= '0;
            ctl_s1_q <= `HP_CTL_IDLE;
            ctl_s2_q <= `HP_CTL_IDLE;
        end
        else
        begin
            din_s1_q <= host_data_in;
            din_s2_q <= din_s1_q;
            adr_s1_q <= host_addr;
            adr_s2_q <= adr_s1_q;
            ctl_s1_q <= {host_cs_n, host_rnw_wr_n, host_oe_rd_n};
            ctl_s2_q <= ctl_s1_q;
        end
    end

    logic cs_n, rnw, oe_n;
    assign cs_n = ctl_s2_q[2];
    assign rnw  = ctl_s2_q[1];
    assign oe_n = ctl_s2_q[0];

    // The strap stages have no reset, so they are flushed while nrst is low.
    always_ff @(posedge sys_clk)
    begin
        style_s1_q <= style_dir_sel;
        style_s2_q <= style_s1_q;
    end

    // Bus style is caught once after reset release and then frozen.
    bus_style_e style_q, style_d;
    logic       style_done_q, style_done_d;

    always_comb
    begin
        style_d      = style_q;
        style_done_d = 1'b1;
        if (!style_done_q)
        begin
            style_d = style_s2_q ? STYLE_DIR : STYLE_STROBE;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            style_q      <= STYLE_DIR;
            style_done_q <= 1'b0;
        end
        else
        begin
            style_q      <= style_d;
            style_done_q <= style_done_d;
        end
    end

    // Access request decoded from the synchronised pins.
    logic wr_req, rd_req;

    always_comb
    begin
        wr_req = 1'b0;
        rd_req = 1'b0;
        if (!cs_n && style_done_q)
        begin
            if (style_q == STYLE_DIR)
            begin
                // Output enable is assumed held low by the host.
                wr_req = !rnw;
                rd_req = rnw;
            end
            else
            begin
                wr_req = !rnw;
                rd_req = !oe_n && rnw;
            end
        end
    end

    // Access engine: one write per strobe, read data held while asked.
    hp_state_e st_q, st_d;
    logic      mem_we;
    logic      irq_sel, msk_sel, stat_sel;
    logic [IRQ_W-1:0] pend_q, pend_d, mask_q, mask_d;
    logic [DATA_W-1:0] dout_d;
    logic      doe_d;
    logic [DATA_W-1:0] mem_rd;

    function automatic logic [DATA_W-1:0] widen(input logic [IRQ_W-1:0] v);
        widen = {{(DATA_W-IRQ_W){1'b0}}, v};
    endfunction

    assign irq_sel  = adr_s2_q == `HP_IRQ_BASE;
    assign msk_sel  = adr_s2_q == `HP_IRQ_MSK_OFS;
    assign stat_sel = adr_s2_q == `HP_STAT_OFS;

    always_comb
    begin
        st_d   = st_q;
        mem_we = 1'b0;
        mask_d = mask_q;
        // New events win over a clearing write in the same cycle.
        pend_d = pend_q | irq_event;
        case (st_q)
            ST_IDLE:  st_d = wr_req ? ST_WRITE : (rd_req ? ST_READ : ST_IDLE);
            ST_WRITE:
            begin
                if (irq_sel)
                    pend_d = (pend_q & ~din_s2_q[IRQ_W-1:0]) | irq_event;
                else if (msk_sel)
                    mask_d = din_s2_q[IRQ_W-1:0];
                else if (!stat_sel)
                    mem_we = 1'b1;
                st_d = ST_HOLD;
            end
            ST_READ:  st_d = rd_req ? ST_READ : ST_IDLE;
            ST_HOLD:  st_d = wr_req ? ST_HOLD : ST_IDLE;
            default:  st_d = ST_IDLE;
        endcase
    end

    always_comb
    begin
        doe_d  = (st_q == ST_READ) && rd_req;
        if (irq_sel)
        begin
            dout_d = widen(pend_q);
        end
        else if (msk_sel)
        begin
            dout_d = widen(mask_q);
        end
        else if (stat_sel)
        begin
            dout_d = {{(DATA_W-2){1'b0}}, style_q == STYLE_DIR,
                      |(pend_q & mask_q)};
        end
        else
        begin
            dout_d = mem_rd;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            st_q            <= ST_IDLE;
            pend_q          <= `HP_ZERO8;
            mask_q          <= `HP_ZERO8;
            host_data_out_q <= `HP_ZERO16;
            host_data_oe_q  <= 1'b0;
            host_irq_n_oe_q <= 1'b0;
            host_irq_n_out_q <= 1'b0;
        end
        else
        begin
            st_q            <= st_d;
            pend_q          <= pend_d;
            mask_q          <= mask_d;
            host_data_out_q <= dout_d;
            host_data_oe_q  <= doe_d;
            host_irq_n_oe_q <= |(pend_q & mask_q);
            host_irq_n_out_q <= 1'b0; // Open drain: only the enable moves.
        end
    end

    hp_word_mem #(
        .DATA_W (DATA_W),
        .ADDR_W (ADDR_W),
        .DEPTH  (`HP_MEM_DEPTH)
    ) u_mem (
        .sys_clk   (sys_clk),
        .nrst      (nrst),
        .wr_en     (mem_we),
        .addr      (adr_s2_q),
        .wr_data   (din_s2_q),
        .rd_data_q (mem_rd)
    );

    property p_no_drive_unselected;
        @(posedge sys_clk) disable iff (!nrst)
        cs_n |=> !host_data_oe_q;
    endproperty
    a_no_drive_unselected: assert property (p_no_drive_unselected)
        else $error("Data bus driven while not selected.");

    property p_no_write_unselected;
        @(posedge sys_clk) disable iff (!nrst)
        cs_n && st_q == ST_IDLE |=> st_q == ST_IDLE;
    endproperty
    a_no_write_unselected: assert property (p_no_write_unselected)
        else $error("Access started without chip select.");

    property p_write_once;
        @(posedge sys_clk) disable iff (!nrst)
        st_q == ST_WRITE |=> st_q == ST_HOLD;
    endproperty
    a_write_once: assert property (p_write_once)
        else $error("Write not followed by hold.");

    property p_dir_read;
        @(posedge sys_clk) disable iff (!nrst)
        style_done_q && style_q == STYLE_DIR && !cs_n && rnw
            && st_q == ST_READ |=> host_data_oe_q;
    endproperty
    a_dir_read: assert property (p_dir_read)
        else $error("Direction-style read did not drive data.");

    property p_strobe_read;
        @(posedge sys_clk) disable iff (!nrst)
        style_q == STYLE_STROBE && oe_n |=> !host_data_oe_q;
    endproperty
    a_strobe_read: assert property (p_strobe_read)
        else $error("Strobe-style drive without read strobe.");

    property p_irq_pending;
        @(posedge sys_clk) disable iff (!nrst)
        |(pend_q & mask_q) |=> host_irq_n_oe_q && !host_irq_n_out_q;
    endproperty
    a_irq_pending: assert property (p_irq_pending)
        else $error("Interrupt not pulled low while pending.");

    property p_irq_release;
        @(posedge sys_clk) disable iff (!nrst)
        !(|(pend_q & mask_q)) |=> !host_irq_n_oe_q;
    endproperty
    a_irq_release: assert property (p_irq_release)
        else $error("Interrupt held without pending condition.");

    property p_style_frozen;
        @(posedge sys_clk) disable iff (!nrst)
        style_done_q |=> $stable(style_q);
    endproperty
    a_style_frozen: assert property (p_style_frozen)
        else $error("Bus style changed after configuration.");

    c_write: cover property (@(posedge sys_clk) st_q == ST_WRITE);
    c_read:  cover property (@(posedge sys_clk) host_data_oe_q);
    c_irq:   cover property (@(posedge sys_clk) host_irq_n_oe_q);
endmodule // host_processor_port

`default_nettype wire

// ==== hw/hp_word_mem.sv ====
// Single-port word memory behind the host port, registered read data.
// Assumes one synchronous clock and a synchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none
`include "host_port_params.svh"

module hp_word_mem #(
    parameter int DATA_W = `HP_DATA_W,
    parameter int ADDR_W = `HP_MEM_AW,
    parameter int DEPTH  = `HP_MEM_DEPTH
) (
    input  wire logic              sys_clk,
    input  wire logic              nrst,
    input  wire logic              wr_en,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wr_data,
    output var  logic [DATA_W-1:0] rd_data_q
);
    logic [DATA_W-1:0] mem [DEPTH];

    always_ff @(posedge sys_clk)
    begin
        if (wr_en)
        begin
            mem[addr] <= wr_data;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            rd_data_q <= '0;
        end
        else
        begin
            rd_data_q <= mem[addr];
        end
    end
endmodule // hp_word_mem

`default_nettype wire
